/* File: core/agio_axis.v */
// agio_axis.v: output pin selector for one axis
// assumes: status inputs come from the motion engine on the same clock
`timescale 1ns/1ns
`include "agio_map.vh"

module agio_axis (
  input  wire               hclk,          // system clock
  input  wire               hresetn,       // async reset, active low
  input  wire               status_mode,   // drive status output mode
  input  wire               devclr_en,     // deviation clear on output 0
  input  wire               use_real,      // compare real, not logical
  input  wire [7:0]         out_bits,      // host output register bits
  input  wire signed [31:0] logical_pos,   // logical position count
  input  wire signed [31:0] real_pos,      // real position count
  input  wire signed [31:0] comp_plus,     // positive compare value
  input  wire signed [31:0] comp_minus,    // negative compare value
  input  wire               drv_busy,      // drive pulses going out
  input  wire               drv_accel,     // accelerating
  input  wire               drv_const,     // constant speed
  input  wire               drv_decel,     // decelerating
  input  wire               accel_rising,  // s-curve magnitude rising
  input  wire               accel_falling, // s-curve magnitude falling
  input  wire               devclr_pulse,  // deviation clear pulse
  output wire [7:0]         pin_out        // registered pin levels
);

  reg  [7:0]         pins_ff;
  reg  [7:0]         nxt_pins;
  wire signed [31:0] sel_pos;
  wire               below_negative_compare_out;
  wire               above_positive_compare_out;

  // position source for the two comparators
  assign sel_pos = use_real ? real_pos : logical_pos;
  assign below_negative_compare_out = (sel_pos < comp_minus);
  assign above_positive_compare_out = (sel_pos > comp_plus);

  // ==========================================================
  // pin selection
  always @* begin
    nxt_pins = out_bits;
    if (status_mode) begin
      nxt_pins[7] = drv_decel;
      nxt_pins[6] = drv_const;
      nxt_pins[5] = drv_accel;
      nxt_pins[4] = drv_busy;
      nxt_pins[3] = below_negative_compare_out;
      nxt_pins[2] = above_positive_compare_out;
      nxt_pins[1] = accel_falling;
      nxt_pins[0] = accel_rising;
    end
    if (devclr_en) begin
      nxt_pins[0] = devclr_pulse;
    end
  end

  // pins held in flops
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_ff <= `AGIO_PIN_RST;
    end else begin
      pins_ff <= nxt_pins;
    end
  end

  assign pin_out = pins_ff;

endmodule

/* File: core/agio_map.vh */
// agio_map.vh: register offsets, field positions and reset values
// assumes: included by the axis general i/o files, definitions only
`ifndef AGIO_MAP_VH
`define AGIO_MAP_VH

// ==========================================================
// register byte offsets, decoded on haddr[7:0]
`define AGIO_OFS_GOUT      8'h00
`define AGIO_OFS_MODE      8'h04
`define AGIO_OFS_XIN       8'h08
`define AGIO_OFS_YIN       8'h0c

// ==========================================================
// field positions
`define AGIO_IN_LSB        8
`define AGIO_IN_MSB        13
`define AGIO_MODE_STAT     0
`define AGIO_MODE_DEVCLR   2
`define AGIO_MODE_REAL     4
`define AGIO_MODE_W        6

// ==========================================================
// reset values
`define AGIO_GOUT_RST      16'h0000
`define AGIO_MODE_RST      6'h00
`define AGIO_PIN_RST       8'h00

// ==========================================================
// data-phase timing, in clock cycles
`define AGIO_WAIT_CYC      0

`endif

/* File: core/agio_top.v */
// agio_top.v: two-axis general i/o block with an ahb-lite register slave
// assumes: one ahb-lite master, single word transfers, inputs synchronous
// to hclk; motion engine supplies positions, compare values and status
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "agio_map.vh"

module agio_top (
  input  wire        hclk,            // system clock, 250 mhz
  input  wire        hresetn,         // async reset, active low
  input  wire        hsel,            // slave select
  input  wire [31:0] haddr,           // byte address
  input  wire [1:0]  htrans,          // transfer type
  input  wire        hwrite,          // write when high
  input  wire [2:0]  hsize,           // transfer size
  input  wire [31:0] hwdata,          // write data
  input  wire        hready,          // bus ready in
  output wire [31:0] hrdata,          // read data
  output wire        hreadyout,       // slave ready
  output wire        hresp,           // response, always okay
  input  wire [5:0]  x_gen_in,        // x general inputs 5..0
  input  wire [5:0]  y_gen_in,        // y general inputs 5..0
  input  wire [63:0] logical_pos,     // logical counts, y in upper word
  input  wire [63:0] real_pos,        // real counts, y in upper word
  input  wire [63:0] comp_plus,       // positive compare values
  input  wire [63:0] comp_minus,      // negative compare values
  input  wire [1:0]  drv_busy,        // drive active per axis
  input  wire [1:0]  drv_accel,       // accelerating per axis
  input  wire [1:0]  drv_const,       // constant speed per axis
  input  wire [1:0]  drv_decel,       // decelerating per axis
  input  wire [1:0]  accel_rising,    // s-curve magnitude rising
  input  wire [1:0]  accel_falling,   // s-curve magnitude falling
  input  wire [1:0]  devclr_pulse,    // deviation clear pulse per axis
  output wire [7:0]  x_gen_out,       // x general outputs 7..0
  output wire [7:0]  y_gen_out        // y general outputs 7..0
);

  // ==========================================================
  // register state
  reg  [15:0]                general_output_reg_ff;
  reg  [`AGIO_MODE_W-1:0]    mode_ff;
  reg  [5:0]                 x_in_ff;
  reg  [5:0]                 y_in_ff;
  reg                        wr_pend_ff;
  reg  [7:0]                 wr_addr_ff;
  reg  [31:0]                rdata_ff;
  reg                        readyout_ff;
  reg                        resp_ff;

  reg  [15:0]                nxt_gout;
  reg  [`AGIO_MODE_W-1:0]    nxt_mode;
  reg  [31:0]                nxt_rdata;

  wire                       addr_phase;
  wire [31:0]                x_input_status_reg;
  wire [31:0]                y_input_status_reg;
  wire [15:0]                gout_view;
  wire [`AGIO_MODE_W-1:0]    mode_view;
  wire [15:0]                pins_all;

  // a valid transfer is taken when hready is high
  // hsize is not decoded: every access is taken as a whole word
  assign addr_phase = hsel & htrans[1] & hready;

  // ==========================================================
  // input status views
  // x inputs in bits 13..8
  assign x_input_status_reg = {18'h00000, x_in_ff, 8'h00};
  assign y_input_status_reg = {18'h00000, y_in_ff, 8'h00};

  // input levels captured every clock
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      x_in_ff <= 6'h00;
      y_in_ff <= 6'h00;
    end else begin
      x_in_ff <= x_gen_in;
      y_in_ff <= y_gen_in;
    end
  end

  // ==========================================================
  // bus address phase capture
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff  <= 1'b0;
      wr_addr_ff  <= 8'h00;
      readyout_ff <= 1'b1;
      resp_ff     <= 1'b0;
    end else begin
      wr_pend_ff  <= addr_phase & hwrite;
      wr_addr_ff  <= haddr[7:0];
      readyout_ff <= 1'b1;
      resp_ff     <= 1'b0;
    end
  end

  // ==========================================================
  // write data phase
  always @* begin
    nxt_gout = general_output_reg_ff;
    nxt_mode = mode_ff;
    if (wr_pend_ff) begin
      case (wr_addr_ff)
        `AGIO_OFS_GOUT: begin
          // y in 15..8, x in 7..0
          nxt_gout = hwdata[15:0];
        end
        `AGIO_OFS_MODE: begin
          nxt_mode = hwdata[`AGIO_MODE_W-1:0];
        end
        default: begin
          nxt_gout = general_output_reg_ff;
        end
      endcase
    end
  end

  // control registers
  // output register clears at reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      general_output_reg_ff <= `AGIO_GOUT_RST;
      mode_ff               <= `AGIO_MODE_RST;
    end else begin
      general_output_reg_ff <= nxt_gout;
      mode_ff               <= nxt_mode;
    end
  end

  // ==========================================================
  // read path: data latched at the address phase, so a write in its
  // data phase on the same edge is forwarded to avoid stale reads
  // (a read straight after a write would otherwise show the old value)
  assign gout_view = nxt_gout;
  assign mode_view = nxt_mode;

  always @* begin
    nxt_rdata = rdata_ff;
    if (addr_phase & ~hwrite) begin
      case (haddr[7:0])
        `AGIO_OFS_GOUT: begin
          nxt_rdata = {16'h0000, gout_view};
        end
        `AGIO_OFS_MODE: begin
          nxt_rdata = {26'h0000000, mode_view};
        end
        `AGIO_OFS_XIN: begin
          nxt_rdata = x_input_status_reg;
        end
        `AGIO_OFS_YIN: begin
          nxt_rdata = y_input_status_reg;
        end
        default: begin
          // unmapped offsets read as zero
          nxt_rdata = 32'h00000000;
        end
      endcase
    end
  end

  // read data register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign hrdata    = rdata_ff;
  assign hreadyout = readyout_ff;
  assign hresp     = resp_ff;

  // ==========================================================
  // per-axis output selectors
  genvar ax;
  generate
    for (ax = 0; ax < 2; ax = ax + 1) begin : g_axis
      // x low byte, y high byte
      agio_axis u_axis (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .status_mode   (mode_ff[`AGIO_MODE_STAT + ax]),
        .devclr_en     (mode_ff[`AGIO_MODE_DEVCLR + ax]),
        .use_real      (mode_ff[`AGIO_MODE_REAL + ax]),
        .out_bits      (general_output_reg_ff[ax*8 +: 8]),
        .logical_pos   (logical_pos[ax*32 +: 32]),
        .real_pos      (real_pos[ax*32 +: 32]),
        .comp_plus     (comp_plus[ax*32 +: 32]),
        .comp_minus    (comp_minus[ax*32 +: 32]),
        .drv_busy      (drv_busy[ax]),
        .drv_accel     (drv_accel[ax]),
        .drv_const     (drv_const[ax]),
        .drv_decel     (drv_decel[ax]),
        .accel_rising  (accel_rising[ax]),
        .accel_falling (accel_falling[ax]),
        .devclr_pulse  (devclr_pulse[ax]),
        .pin_out       (pins_all[ax*8 +: 8])
      );
    end
  endgenerate

  assign x_gen_out = pins_all[7:0];
  assign y_gen_out = pins_all[15:8];

endmodule

/* File: verif/agio_field.sv */
// agio_field.sv: sensors on the general inputs of both axes
// assumes: pins idle high through pull-ups until the bench sets them
`timescale 1ns/1ns
module agio_field (
  input  wire       hclk,   // clock
  output reg  [5:0] x_pins, // x levels
  output reg  [5:0] y_pins  // y levels
);
  // ====
  // idle high, new levels just after an edge
  initial begin
    x_pins = 6'h3f;
    y_pins = 6'h3f;
  end
  task drive(input [5:0] x, input [5:0] y);
    begin
      @(posedge hclk);
      x_pins <= x;
      y_pins <= y;
    end
  endtask
endmodule

/* File: verif/agio_properties.sv */
// agio_properties.sv: port assertions for the general i/o block
// assumes: bound into agio_top, hready tied to hreadyout
`timescale 1ns/1ns
`include "agio_map.vh"
module agio_properties (
  input wire        hclk,          // clock
  input wire        hresetn,       // reset
  input wire        hsel,          // select
  input wire [31:0] haddr,         // address
  input wire [1:0]  htrans,        // type
  input wire        hwrite,        // write
  input wire [31:0] hwdata,        // wdata
  input wire        hready,        // ready
  input wire [31:0] hrdata,        // rdata
  input wire [5:0]  x_gen_in,      // x inputs
  input wire [63:0] logical_pos,   // logical
  input wire [63:0] real_pos,      // real
  input wire [63:0] comp_plus,     // compare +
  input wire [63:0] comp_minus,    // compare -
  input wire [1:0]  accel_rising,  // rising
  input wire [1:0]  accel_falling, // falling
  input wire [1:0]  devclr_pulse,  // dev clear
  input wire [7:0]  x_gen_out,     // x outputs
  input wire [7:0]  y_gen_out      // y outputs
);
  // ====
  // mirror of the mode and output registers
  reg [7:0]  wa_ff;
  reg        ww_ff;
  reg        rx_ff;
  reg [5:0]  md_ff;
  reg [15:0] go_ff;
  wire       take = hsel & htrans[1] & hready;
  wire signed [31:0] pos = md_ff[4] ? real_pos[31:0] : logical_pos[31:0];
  // track writes at their data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wa_ff <= 8'h00;
      ww_ff <= 1'b0;
      rx_ff <= 1'b0;
      md_ff <= 6'h00;
      go_ff <= 16'h0000;
    end else if (hready) begin
      wa_ff <= haddr[7:0];
      ww_ff <= take & hwrite;
      rx_ff <= take & ~hwrite & (haddr[7:0] == `AGIO_OFS_XIN);
      if (ww_ff && wa_ff == `AGIO_OFS_MODE) md_ff <= hwdata[5:0];
      if (ww_ff && wa_ff == `AGIO_OFS_GOUT) go_ff <= hwdata[15:0];
    end
  end
  // ====
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rst; disable iff (1'b0) !hresetn |-> {x_gen_out, y_gen_out} == 16'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not low in reset");
  property p_xreg; $past(md_ff[0] | md_ff[2]) == 1'b0 |-> x_gen_out == $past(go_ff[7:0]); endproperty
  a_xreg: assert property (p_xreg) else $error("x outputs off register");
  property p_yreg; $past(md_ff[1] | md_ff[3]) == 1'b0 |-> y_gen_out == $past(go_ff[15:8]); endproperty
  a_yreg: assert property (p_yreg) else $error("y outputs off register");
  property p_lt; $past(md_ff[0]) |-> x_gen_out[3] == $past(pos < $signed(comp_minus[31:0])); endproperty
  a_lt: assert property (p_lt) else $error("below compare wrong");
  property p_gt; $past(md_ff[0]) |-> x_gen_out[2] == $past(pos > $signed(comp_plus[31:0])); endproperty
  a_gt: assert property (p_gt) else $error("above compare wrong");
  property p_fall; $past(md_ff[0]) |-> x_gen_out[1] == $past(accel_falling[0]); endproperty
  a_fall: assert property (p_fall) else $error("falling trend wrong");
  property p_rise; $past(md_ff[0] & ~md_ff[2]) |-> x_gen_out[0] == $past(accel_rising[0]); endproperty
  a_rise: assert property (p_rise) else $error("rising trend wrong");
  property p_devclr; $past(md_ff[2]) |-> x_gen_out[0] == $past(devclr_pulse[0]); endproperty
  a_devclr: assert property (p_devclr) else $error("deviation clear wrong");
  // read data holds the pin level sampled one cycle before the address phase
  property p_xin; rx_ff |-> hrdata[13:8] == $past(x_gen_in, 2); endproperty
  a_xin: assert property (p_xin) else $error("x input status wrong");
endmodule
bind agio_top agio_properties u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .x_gen_in(x_gen_in), .logical_pos(logical_pos), .real_pos(real_pos),
  .comp_plus(comp_plus), .comp_minus(comp_minus), .accel_rising(accel_rising),
  .accel_falling(accel_falling), .devclr_pulse(devclr_pulse), .x_gen_out(x_gen_out),
  .y_gen_out(y_gen_out));

/* File: verif/agio_top_test.sv */
// agio_top_test.sv: bench for the general i/o block
// assumes: one ahb-lite master, motion engine played by the bench
`timescale 1ns/1ns
`include "agio_map.vh"
module agio_top_test;
  reg         hclk, hresetn, hsel, hwrite;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize;
  reg  [31:0] haddr, hwdata, q;
  wire        hready, hresp;
  wire [31:0] hrdata;
  wire [5:0]  x_gen_in, y_gen_in;
  wire [7:0]  x_out, y_out;
  reg  [63:0] logical_pos, real_pos, comp_plus, comp_minus;
  reg  [1:0]  drv_busy, drv_accel, drv_const, drv_decel;
  reg  [1:0]  accel_rising, accel_falling, devclr_pulse;
  reg  [5:0]  v;
  integer     mismatches, checks_done, cyc, i;
  agio_field fld (.hclk(hclk), .x_pins(x_gen_in), .y_pins(y_gen_in));
  agio_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .x_gen_in(x_gen_in), .y_gen_in(y_gen_in), .logical_pos(logical_pos),
    .real_pos(real_pos), .comp_plus(comp_plus), .comp_minus(comp_minus),
    .drv_busy(drv_busy), .drv_accel(drv_accel), .drv_const(drv_const),
    .drv_decel(drv_decel), .accel_rising(accel_rising),
    .accel_falling(accel_falling), .devclr_pulse(devclr_pulse),
    .x_gen_out(x_out), .y_gen_out(y_out));
  // ====
  // clock and hang limit
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
  end
  // ====
  // bus cycle, compares and closing
  task bus(input [7:0] a, input w, input [31:0] d, output [31:0] r);
    begin
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      r = hrdata;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (got !== e) begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, e);
      end
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] e);
    begin
      bus(a, 1'b0, 32'h0, q);
      cmp(q, e);
    end
  endtask
  task pin_chk(input [15:0] e);
    begin
      @(posedge hclk);
      @(negedge hclk);
      cmp({16'h0, y_out, x_out}, {16'h0, e});
      @(posedge hclk);
    end
  endtask
  // one engine state on the x axis, then the pins of both axes
  task st(input [31:0] p, input [5:0] s, input [15:0] e);
    begin
      logical_pos[31:0] <= p;
      real_pos[31:0] <= p + 32'h12c;
      {drv_decel[0], drv_const[0], drv_accel[0], drv_busy[0]} <= s[5:2];
      {accel_falling[0], accel_rising[0]} <= s[1:0];
      pin_chk(e);
    end
  endtask
  task tally_and_finish;
    begin
      $display("mismatches %0d checks %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // ====
  // main sequence
  initial begin
    {mismatches, checks_done, cyc} = 96'h0;
    {hresetn, hsel, htrans, hwrite, haddr, hwdata} = {1'b1, 68'h0};
    hsize = 3'h2;
    {logical_pos, real_pos, drv_busy, drv_accel, drv_const, drv_decel} = 136'h0;
    {accel_rising, accel_falling, devclr_pulse} = 6'h0;
    // a real falling edge, so the async reset is seen at time zero
    hresetn <= 1'b0;
    comp_minus = 64'h64;
    comp_plus = 64'hc8;
    repeat (4) @(posedge hclk);
    pin_chk(16'h0000);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    rd_chk(`AGIO_OFS_GOUT, 32'h0);
    bus(`AGIO_OFS_GOUT, 1'b1, 32'hffff_c3a5, q);
    rd_chk(`AGIO_OFS_GOUT, 32'h0000_c3a5);
    pin_chk(16'hc3a5);
    rd_chk(8'h10, 32'h0);
    for (i = 0; i < 2; i = i + 1) begin
      v = 6'h2a ^ {6{i[0]}};
      fld.drive(v, ~v);
      repeat (3) @(posedge hclk);
      rd_chk(`AGIO_OFS_XIN, {18'h0, v, 8'h0});
      rd_chk(`AGIO_OFS_YIN, {18'h0, ~v, 8'h0});
    end
    bus(`AGIO_OFS_MODE, 1'b1, 32'h1, q);
    st(32'h32, 6'h0d, 16'hc339);
    st(32'h64, 6'h14, 16'hc350);
    st(32'hfa, 6'h26, 16'hc396);
    st(32'hffff_fffb, 6'h00, 16'hc308);
    st(32'hc8, 6'h00, 16'hc300);
    bus(`AGIO_OFS_MODE, 1'b1, 32'h11, q);
    st(32'h0, 6'h00, 16'hc304);
    bus(`AGIO_OFS_MODE, 1'b1, 32'h05, q);
    devclr_pulse <= 2'h1;
    st(32'h0, 6'h01, 16'hc309);
    devclr_pulse <= 2'h0;
    st(32'h0, 6'h01, 16'hc308);
    bus(`AGIO_OFS_MODE, 1'b1, 32'h02, q);
    drv_busy[1] <= 1'b1;
    accel_rising[1] <= 1'b1;
    st(32'h0, 6'h00, 16'h11a5);
    bus(`AGIO_OFS_MODE, 1'b1, 32'h0a, q);
    rd_chk(`AGIO_OFS_MODE, 32'h0000_000a);
    st(32'h0, 6'h00, 16'h10a5);
    bus(`AGIO_OFS_MODE, 1'b1, 32'h0, q);
    st(32'h0, 6'h00, 16'hc3a5);
    // reset in mid-run: pins and registers must clear
    hresetn <= 1'b0;
    pin_chk(16'h0000);
    hresetn <= 1'b1;
    rd_chk(`AGIO_OFS_GOUT, 32'h0);
    pin_chk(16'h0000);
    tally_and_finish;
  end
endmodule
